// ---- verilog/dmc_mode_ctl.sv ----
// Mode-register decode, driver calibration and termination switching.
// Assumes command pins are synchronous to mclk_in; odt pin is asynchronous.
// Notes on behaviour
// RL1: Controller keeps loop enabled for normal work.
// RL2: Self-refresh turns loop off, exit restores.
// RL3: Controller waits 200 clocks before reads.
// RL4: Register 2 loads on bank code two.
// RL5: Controller precharges, clock enable high first.
// RL6: Register 2 reserved bits written zero.
// RL7: Register 3 written all zero.
// RL8: Every calibration command followed by exit.
// RL9: Main register programmed before adjustment.
// RL10: Decode calibration field into five modes.
// RL11: Default setting followed by exit code.
// RL12: Drive high or low levels on outputs.
// RL13: Drivers follow command after test delay.
// RL14: Controller sets burst four before adjust.
// RL15: Same code on all lines, fixed order.
// RL16: Decode adjust code into pull steps.
// RL17: One shared strength for all outputs.
// RL18: Strength saturates within sixteen steps.
// RL19: Controller delivers code at write latency.
// RL20: Termination pin switches all pin terminations.
// RL21: No termination during self-refresh.
// RL22: Nominal field picks one switch pair.
// RL23: Nominal field from address bits two, six.
// RL24: Calibration field from register 1 bits.
// RL25: Reserved values leave strengths unchanged.
module dmc_mode_ctl (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      cmd_valid_in,
  input  wire logic                      cs_n_in,
  input  wire logic                      ras_n_in,
  input  wire logic                      cas_n_in,
  input  wire logic                      we_n_in,
  input  wire logic [1:0]                bank_sel_in,
  input  wire logic [dmc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                      self_refresh_enter_in,
  input  wire logic                      self_refresh_exit_in,
  input  wire logic                      code_valid_in,
  input  wire logic [3:0]                code_in,
  input  wire logic                      on_die_termination_ctl_in,
  output logic                           dll_on_out,
  output logic                           self_refresh_out,
  output logic [dmc_pkg::ADDR_W-1:0]     emr2_out,
  output logic [dmc_pkg::ADDR_W-1:0]     emr3_out,
  output logic [2:0]                     cal_mode_out,
  output logic                           drive_en_out,
  output logic                           drive_level_out,
  output logic                           strobe_level_out,
  output logic                           strobe_n_level_out,
  output logic                           read_strobe_drive_out,
  output logic [dmc_pkg::STEP_W-1:0]     pull_up_out,
  output logic [dmc_pkg::STEP_W-1:0]     pull_down_out,
  output logic [2:0]                     term_switch_out,
  output logic                           term_on_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]                  odt_sync;
    logic                        dll_dis;
    logic                        sref;
    logic [dmc_pkg::ADDR_W-1:0]  emr2;
    logic [dmc_pkg::ADDR_W-1:0]  emr3;
    logic [2:0]                  cal_mode;
    logic [1:0]                  rtt;
    logic                        read_strobe_complement_en;
    dmc_pkg::dmc_drive_t         drv_target;
    dmc_pkg::dmc_drive_t         drv_now;
    logic [7:0]                  drv_cnt;
    logic [dmc_pkg::STEP_W-1:0]  pull_up;
    logic [dmc_pkg::STEP_W-1:0]  pull_down;
    logic [2:0]                  term_switch;
    logic                        term_on;
    logic                        dll_on;
    logic                        drive_en;
    logic                        drive_lvl;
    logic                        strobe_lvl;
    logic                        strobe_n_lvl;
    logic                        read_strobe_complement_drive;
  } dmc_state_t;

  localparam logic [7:0] IMP_CNT = 8'(dmc_pkg::IMP_TEST_CYC);

  dmc_state_t st;
  dmc_state_t next_st;

  logic                       extended_mode_load_cmd_cmd;
  logic                       pu_inc;
  logic                       pu_dec;
  logic                       pd_inc;
  logic                       pd_dec;
  logic [dmc_pkg::STEP_W-1:0] pu_next;
  logic [dmc_pkg::STEP_W-1:0] pd_next;
  logic [2:0]                 cal_field;

  assign extended_mode_load_cmd_cmd  = cmd_valid_in && !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
  assign cal_field = addr_in[dmc_pkg::CAL_MSB:dmc_pkg::CAL_LSB]; // RL24

  // ****************************************
  // Adjust code decode
  // ****************************************
  always_comb begin
    pu_inc = 1'b0;
    pu_dec = 1'b0;
    pd_inc = 1'b0;
    pd_dec = 1'b0;
    if (code_valid_in && st.cal_mode == dmc_pkg::CAL_ADJUST) begin
      case (code_in) // RL16
        dmc_pkg::ADJ_PU_INC:        pu_inc = 1'b1;
        dmc_pkg::ADJ_PU_DEC:        pu_dec = 1'b1;
        dmc_pkg::ADJ_PD_INC:        pd_inc = 1'b1;
        dmc_pkg::ADJ_PD_DEC:        pd_dec = 1'b1;
        dmc_pkg::ADJ_BOTH_INC: begin
          pu_inc = 1'b1;
          pd_inc = 1'b1;
        end
        dmc_pkg::ADJ_PU_DEC_PD_INC: begin
          pu_dec = 1'b1;
          pd_inc = 1'b1;
        end
        dmc_pkg::ADJ_PU_INC_PD_DEC: begin
          pu_inc = 1'b1;
          pd_dec = 1'b1;
        end
        dmc_pkg::ADJ_BOTH_DEC: begin
          pu_dec = 1'b1;
          pd_dec = 1'b1;
        end
        default: ; // RL25
      endcase
    end
  end

  dmc_strength_step #(.W(dmc_pkg::STEP_W)) u_pu (
    .cur_in   (st.pull_up),
    .inc_in   (pu_inc),
    .dec_in   (pu_dec),
    .next_out (pu_next)
  );

  dmc_strength_step #(.W(dmc_pkg::STEP_W)) u_pd (
    .cur_in   (st.pull_down),
    .inc_in   (pd_inc),
    .dec_in   (pd_dec),
    .next_out (pd_next)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.odt_sync = {st.odt_sync[0], on_die_termination_ctl_in};
    next_st.pull_up   = pu_next; // RL17
    next_st.pull_down = pd_next; // RL17
    if (self_refresh_enter_in) begin
      next_st.sref = 1'b1; // RL2
    end else if (self_refresh_exit_in) begin
      next_st.sref = 1'b0; // RL2
    end
    if (extended_mode_load_cmd_cmd && !st.sref) begin
      case (bank_sel_in)
        dmc_pkg::BANK_EMR1: begin
          next_st.dll_dis = addr_in[dmc_pkg::DLL_DIS_BIT];
          next_st.rtt     = {addr_in[dmc_pkg::RTT_HI_BIT], addr_in[dmc_pkg::RTT_LO_BIT]}; // RL23
          next_st.read_strobe_complement_en = addr_in[dmc_pkg::READ_STROBE_COMPLEMENT_EN_BIT];
          case (cal_field) // RL10
            dmc_pkg::CAL_EXIT: begin
              next_st.cal_mode   = cal_field;
              next_st.drv_target = dmc_pkg::DMC_DRV_OFF;
            end
            dmc_pkg::CAL_DRIVE_HIGH: begin
              next_st.cal_mode   = cal_field;
              next_st.drv_target = dmc_pkg::DMC_DRV_HIGH;
            end
            dmc_pkg::CAL_DRIVE_LOW: begin
              next_st.cal_mode   = cal_field;
              next_st.drv_target = dmc_pkg::DMC_DRV_LOW;
            end
            dmc_pkg::CAL_ADJUST: begin
              next_st.cal_mode = cal_field;
            end
            dmc_pkg::CAL_DEFAULT: begin
              next_st.cal_mode  = cal_field;
              next_st.pull_up   = dmc_pkg::STEP_DEFAULT;
              next_st.pull_down = dmc_pkg::STEP_DEFAULT;
            end
            default: ; // RL25
          endcase
        end
        dmc_pkg::BANK_EMR2: next_st.emr2 = addr_in; // RL4
        dmc_pkg::BANK_EMR3: next_st.emr3 = addr_in;
        default: ;
      endcase
    end
    // Delayed driver turn-on and turn-off
    if (st.drv_target != st.drv_now) begin
      if (st.drv_cnt + 8'h01 >= IMP_CNT) begin
        next_st.drv_now = st.drv_target; // RL13
        next_st.drv_cnt = 8'h00;
      end else begin
        next_st.drv_cnt = st.drv_cnt + 8'h01; // RL13
      end
    end else begin
      next_st.drv_cnt = 8'h00;
    end
    if (next_st.drv_target != st.drv_target) begin
      next_st.drv_cnt = 8'h00;
    end
    // Termination from pin, forced off in self-refresh
    next_st.term_on = st.odt_sync[1] && !st.sref && st.rtt != dmc_pkg::RTT_OFF; // RL20 RL21
    case (st.rtt) // RL22
      dmc_pkg::RTT_75:  next_st.term_switch = next_st.term_on ? 3'h1 : 3'h0;
      dmc_pkg::RTT_150: next_st.term_switch = next_st.term_on ? 3'h2 : 3'h0;
      dmc_pkg::RTT_50:  next_st.term_switch = next_st.term_on ? 3'h4 : 3'h0;
      default:          next_st.term_switch = 3'h0;
    endcase
    // Output flops, loaded from the next state so timing is unchanged
    next_st.dll_on       = !next_st.dll_dis && !next_st.sref; // RL2
    next_st.drive_en     = next_st.drv_now != dmc_pkg::DMC_DRV_OFF; // RL13
    next_st.drive_lvl    = next_st.drv_now == dmc_pkg::DMC_DRV_HIGH; // RL12
    next_st.strobe_lvl   = next_st.drv_now == dmc_pkg::DMC_DRV_HIGH; // RL12
    next_st.strobe_n_lvl = next_st.drv_now == dmc_pkg::DMC_DRV_LOW; // RL12
    next_st.read_strobe_complement_drive   = next_st.read_strobe_complement_en && next_st.drv_now != dmc_pkg::DMC_DRV_OFF; // RL12
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '{odt_sync: 2'h0, dll_dis: 1'b0, sref: 1'b0, emr2: '0, emr3: '0,
              cal_mode: dmc_pkg::CAL_EXIT, rtt: dmc_pkg::RTT_OFF, read_strobe_complement_en: 1'b0,
              drv_target: dmc_pkg::DMC_DRV_OFF, drv_now: dmc_pkg::DMC_DRV_OFF,
              drv_cnt: 8'h00, pull_up: dmc_pkg::STEP_DEFAULT,
              pull_down: dmc_pkg::STEP_DEFAULT, term_switch: 3'h0, term_on: 1'b0,
              dll_on: 1'b1, drive_en: 1'b0, drive_lvl: 1'b0, strobe_lvl: 1'b0,
              strobe_n_lvl: 1'b0, read_strobe_complement_drive: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dll_on_out            = st.dll_on; // RL2
  assign self_refresh_out      = st.sref;
  assign emr2_out              = st.emr2;
  assign emr3_out              = st.emr3;
  assign cal_mode_out          = st.cal_mode;
  assign drive_en_out          = st.drive_en;
  assign drive_level_out       = st.drive_lvl; // RL12
  assign strobe_level_out      = st.strobe_lvl; // RL12
  assign strobe_n_level_out    = st.strobe_n_lvl; // RL12
  assign read_strobe_drive_out = st.read_strobe_complement_drive; // RL12
  assign pull_up_out           = st.pull_up;
  assign pull_down_out         = st.pull_down;
  assign term_switch_out       = st.term_switch;
  assign term_on_out           = st.term_on;

endmodule : dmc_mode_ctl

// ---- verilog/dmc_pkg.sv ----
// Shared constants for the mode-register, driver calibration and termination block.
// Assumes a single 50 MHz clock domain and command pins sampled on its rising edge.
package dmc_pkg;

  // ****************************************
  // Command and field layout
  // ****************************************
  localparam int          ADDR_W          = 14;
  localparam int          CAL_LSB         = 7;
  localparam int          CAL_MSB         = 9;
  localparam int          RTT_LO_BIT      = 2;
  localparam int          RTT_HI_BIT      = 6;
  localparam int          READ_STROBE_COMPLEMENT_EN_BIT     = 11;
  localparam int          DLL_DIS_BIT     = 0;
  localparam logic [1:0]  BANK_EMR1       = 2'h1;
  localparam logic [1:0]  BANK_EMR2       = 2'h2;
  localparam logic [1:0]  BANK_EMR3       = 2'h3;

  // ****************************************
  // Calibration mode codes
  // ****************************************
  localparam logic [2:0]  CAL_EXIT        = 3'h0;
  localparam logic [2:0]  CAL_DRIVE_HIGH  = 3'h1;
  localparam logic [2:0]  CAL_DRIVE_LOW   = 3'h2;
  localparam logic [2:0]  CAL_ADJUST      = 3'h4;
  localparam logic [2:0]  CAL_DEFAULT     = 3'h7;

  // ****************************************
  // Adjust codes, bit time 0 in the msb
  // ****************************************
  localparam logic [3:0]  ADJ_NOP         = 4'h0;
  localparam logic [3:0]  ADJ_PU_INC      = 4'h1;
  localparam logic [3:0]  ADJ_PU_DEC      = 4'h2;
  localparam logic [3:0]  ADJ_PD_INC      = 4'h4;
  localparam logic [3:0]  ADJ_PD_DEC      = 4'h8;
  localparam logic [3:0]  ADJ_BOTH_INC    = 4'h5;
  localparam logic [3:0]  ADJ_PU_DEC_PD_INC = 4'h6;
  localparam logic [3:0]  ADJ_PU_INC_PD_DEC = 4'h9;
  localparam logic [3:0]  ADJ_BOTH_DEC    = 4'ha;

  // ****************************************
  // Strength range and defaults
  // ****************************************
  localparam int          STEP_W          = 4;
  localparam logic [3:0]  STEP_MAX        = 4'hf;
  localparam logic [3:0]  STEP_DEFAULT    = 4'h8;

  // ****************************************
  // Termination selection
  // ****************************************
  localparam logic [1:0]  RTT_OFF         = 2'h0;
  localparam logic [1:0]  RTT_75          = 2'h1;
  localparam logic [1:0]  RTT_150         = 2'h2;
  localparam logic [1:0]  RTT_50          = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_MHZ         = 50;
  localparam int          IMP_TEST_NS     = 12;
  localparam int          IMP_TEST_CYC    = (IMP_TEST_NS * CLK_MHZ + 999) / 1000;
  localparam int          DLL_LOCK_CYC    = 200;

  typedef enum logic [1:0] {
    DMC_DRV_OFF   = 2'b00,
    DMC_DRV_HIGH  = 2'b01,
    DMC_DRV_LOW   = 2'b10
  } dmc_drive_t;

endpackage : dmc_pkg

// ---- verilog/dmc_strength_step.sv ----
// Saturating up/down step for one driver strength setting.
// Assumes the caller applies the result on its own clock.
module dmc_strength_step #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] cur_in,
  input  wire logic         inc_in,
  input  wire logic         dec_in,
  output logic      [W-1:0] next_out
);

  if (W < 2) begin : g_bad_width
    $error("dmc_strength_step: width too small");
  end

  // Limits hold, further steps ignored
  always_comb begin
    next_out = cur_in;
    if (inc_in && !dec_in && cur_in != {W{1'b1}}) begin
      next_out = cur_in + {{(W-1){1'b0}}, 1'b1}; // RL18
    end else if (dec_in && !inc_in && cur_in != {W{1'b0}}) begin
      next_out = cur_in - {{(W-1){1'b0}}, 1'b1}; // RL18
    end
  end

endmodule : dmc_strength_step

// ---- test/dmc_mode_ctl_sva.sv ----
// Checker for mode loads, calibration drive, strength steps and self-refresh.
// Bound to dmc_mode_ctl; sees only its ports, one clock domain.
module dmc_mode_ctl_sva (
  input wire logic                       mclk_in, rst_n_in, cmd_valid_in, code_valid_in,
  input wire logic                       cs_n_in, ras_n_in, cas_n_in, we_n_in,
  input wire logic [1:0]                 bank_sel_in,
  input wire logic [dmc_pkg::ADDR_W-1:0] addr_in, emr2_out,
  input wire logic [3:0]                 code_in,
  input wire logic [2:0]                 cal_mode_out,
  input wire logic [dmc_pkg::STEP_W-1:0] pull_up_out, pull_down_out,
  input wire logic                       dll_on_out, self_refresh_out, drive_en_out,
  input wire logic                       drive_level_out, strobe_level_out, term_on_out,
  input wire logic                       strobe_n_level_out, read_strobe_drive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic load2;
  logic adj;
  assign load2 = cmd_valid_in && !(cs_n_in || ras_n_in || cas_n_in || we_n_in)
    && !self_refresh_out && bank_sel_in == dmc_pkg::BANK_EMR2;
  assign adj = code_valid_in && cal_mode_out == dmc_pkg::CAL_ADJUST;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_enter_high;
    $changed(cal_mode_out) && cal_mode_out == dmc_pkg::CAL_DRIVE_HIGH;
  endsequence
  sequence s_enter_low;
    $changed(cal_mode_out) && cal_mode_out == dmc_pkg::CAL_DRIVE_LOW;
  endsequence
  sequence s_exit;
    $changed(cal_mode_out) && cal_mode_out == dmc_pkg::CAL_EXIT;
  endsequence
  emr2_load_a: assert property (load2 |=> emr2_out == $past(addr_in))
    else $error("ext reg 2 did not take the address value");
  drive_high_a: assert property (s_enter_high |=> drive_en_out && drive_level_out
    && strobe_level_out && !strobe_n_level_out) else $error("drive high levels wrong");
  drive_low_a: assert property (s_enter_low |=> drive_en_out && !drive_level_out
    && !strobe_level_out && strobe_n_level_out) else $error("drive low levels wrong");
  drive_off_a: assert property (s_exit |=> !drive_en_out)
    else $error("drivers still on after exit delay");
  read_strobe_a: assert property (read_strobe_drive_out |-> drive_en_out)
    else $error("read strobe driven outside drive mode");
  sr_loop_off_a: assert property (self_refresh_out |-> !dll_on_out)
    else $error("loop on during self-refresh");
  sr_term_off_a: assert property (self_refresh_out && $past(self_refresh_out, 3)
    |-> !term_on_out) else $error("termination on during self-refresh");
  pull_up_step_a: assert property (adj && code_in == dmc_pkg::ADJ_PU_INC
    && pull_up_out != 4'hf |=> pull_up_out == $past(pull_up_out) + 4'h1)
    else $error("pull-up did not step up by one");
  pull_down_sat_a: assert property (adj && code_in == dmc_pkg::ADJ_PD_DEC
    && pull_down_out == 4'h0 |=> pull_down_out == 4'h0) else $error("pull-down wrapped");
  reserved_code_a: assert property (adj && !(code_in inside {4'h1, 4'h2, 4'h4, 4'h8,
    4'h5, 4'h6, 4'h9, 4'ha}) |=> $stable(pull_up_out) && $stable(pull_down_out))
    else $error("strength moved on a no-change code");
endmodule : dmc_mode_ctl_sva
bind dmc_mode_ctl dmc_mode_ctl_sva i_sva (.*);

// ---- test/dmc_ctl_model.sv ----
// Memory controller model: command, adjust code, self-refresh and termination pins.
// Assumes one clock; every pin changes 2 ns after mclk_in rises.
module dmc_ctl_model (
  input  wire logic                  mclk_in,
  output logic                       cmd_valid_out,
  output logic [3:0]                 strobes_n_out,
  output logic [1:0]                 bank_sel_out,
  output logic [dmc_pkg::ADDR_W-1:0] addr_out,
  output logic                       sr_enter_out,
  output logic                       sr_exit_out,
  output logic                       code_valid_out,
  output logic [3:0]                 code_out,
  output logic                       odt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cmd_valid_out, sr_enter_out, sr_exit_out, code_valid_out, odt_out} = 5'h0;
    {strobes_n_out, bank_sel_out, addr_out, code_out} = 24'hf00000;
  end
  // Any command pattern for one cycle, then valid low and the inverse on the other pins
  task automatic command(input logic vld, input logic [3:0] stb, input logic [1:0] bank,
                         input logic [13:0] value);
    @(posedge mclk_in) #2;
    {cmd_valid_out, strobes_n_out, bank_sel_out, addr_out} = {vld, stb, bank, value};
    @(posedge mclk_in) #2;
    {cmd_valid_out, strobes_n_out, bank_sel_out, addr_out} = {1'b0, ~stb, ~bank, ~value};
  endtask : command
  // Caller has banks precharged, clock enable high, loop settled
  task automatic mode_load(input logic [1:0] bank, input logic [13:0] value);
    command(1'b1, 4'h0, bank, value);
  endtask : mode_load
  // Whole code as one word, bit 3 first in time, at write latency
  task automatic send_code(input logic [3:0] code);
    @(posedge mclk_in) #2;
    {code_valid_out, code_out} = {1'b1, code};
    @(posedge mclk_in) #2;
    {code_valid_out, code_out} = {1'b0, ~code};
  endtask : send_code
  task automatic pulse_sr(input logic enter);
    @(posedge mclk_in) #2;
    {sr_enter_out, sr_exit_out} = {enter, !enter};
    @(posedge mclk_in) #2;
    {sr_enter_out, sr_exit_out} = 2'h0;
  endtask : pulse_sr
  task automatic set_odt(input logic level);
    @(posedge mclk_in) #2;
    odt_out = level;
  endtask : set_odt
endmodule : dmc_ctl_model

// ---- test/tb.sv ----
// Bench for dmc_mode_ctl: controller model drives the inputs, bench checks outputs.
// Assumes the checker is bound beside the design.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       mclk_in, rst_n_in, cmd_valid_in, cs_n_in, ras_n_in, cas_n_in;
  logic                       we_n_in, self_refresh_enter_in, self_refresh_exit_in, rq;
  logic                       code_valid_in, on_die_termination_ctl_in, term_on_out;
  logic [1:0]                 bank_sel_in;
  logic [dmc_pkg::ADDR_W-1:0] addr_in, emr2_out, emr3_out, v;
  logic [3:0]                 code_in, pull_up_out, pull_down_out, exp_pu, exp_pd;
  logic [2:0]                 cal_mode_out, term_switch_out;
  logic                       dll_on_out, self_refresh_out, drive_en_out, drive_level_out;
  logic                       strobe_level_out, strobe_n_level_out, read_strobe_drive_out;
  logic [31:0]                seed;
  int                         mismatches, samples_checked, cycles, k;
  dmc_mode_ctl i_dut (.*);
  dmc_ctl_model i_ctl (.mclk_in(mclk_in), .cmd_valid_out(cmd_valid_in),
    .strobes_n_out({cs_n_in, ras_n_in, cas_n_in, we_n_in}), .bank_sel_out(bank_sel_in),
    .addr_out(addr_in), .sr_enter_out(self_refresh_enter_in), .code_out(code_in),
    .sr_exit_out(self_refresh_exit_in), .code_valid_out(code_valid_in),
    .odt_out(on_die_termination_ctl_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [3:0] step(input logic [3:0] cur, input logic up, input logic dn);
    if (up && cur != 4'hf) return cur + 4'h1;
    if (dn && cur != 4'h0) return cur - 4'h1;
    return cur;
  endfunction : step
  function automatic logic [13:0] reg1(input logic [2:0] cal, input logic [1:0] rtt,
                                       input logic read_strobe_complement);
    return {2'h0, read_strobe_complement, 1'h0, cal, rtt[1], 3'h0, rtt[0], 2'h0};
  endfunction : reg1
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic adjust(input logic [3:0] c);
    i_ctl.send_code(c);
    exp_pu = step(exp_pu, c inside {4'h1, 4'h5, 4'h9}, c inside {4'h2, 4'h6, 4'ha});
    exp_pd = step(exp_pd, c inside {4'h4, 4'h5, 4'h6}, c inside {4'h8, 4'h9, 4'ha});
    check({pull_up_out, pull_down_out}, {exp_pu, exp_pd});
  endtask : adjust
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    {rst_n_in, seed, exp_pu, exp_pd} = {1'b0, 32'h633a, 8'h88};
    repeat (5) @(posedge mclk_in);
    check({dll_on_out, pull_up_out, pull_down_out, cal_mode_out, emr2_out}, {9'h188, 17'h0});
    #2 rst_n_in = 1'b1;
    i_ctl.mode_load(2'h2, 14'h80);
    i_ctl.mode_load(2'h3, 14'h0);
    check({emr2_out, emr3_out}, 28'h0200000);
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      v = seed[13:0];
      i_ctl.mode_load(2'h2, v);
      check(emr2_out, v);
    end
    for (k = 0; k < 16; k++) begin
      i_ctl.command(k != 0, k[3:0], 2'h2, ~v);
      check(emr2_out, v);
    end
    i_ctl.mode_load(2'h1, 14'h1);
    check(dll_on_out, 1'b0);
    i_ctl.mode_load(2'h1, 14'h0);
    check(dll_on_out, 1'b1);
    for (k = 1; k < 4; k++) begin
      rq = seed[k];
      i_ctl.mode_load(2'h1, reg1(k[2:0], 2'h0, rq));
      @(posedge mclk_in) #2;
      check({cal_mode_out, drive_en_out, drive_level_out, strobe_level_out, strobe_n_level_out,
        read_strobe_drive_out}, (k == 3) ? 8'h0 : {k[2:0], 1'b1, k == 1, k == 1, k == 2, rq});
      i_ctl.mode_load(2'h1, reg1(3'h0, 2'h0, rq));
      check(drive_en_out, k != 3);
      @(posedge mclk_in) #2;
      check(drive_en_out, 1'b0);
    end
    i_ctl.mode_load(2'h0, 14'h2);
    i_ctl.mode_load(2'h1, reg1(3'h4, 2'h0, 1'b0));
    check(cal_mode_out, 3'h4);
    repeat (9) adjust(4'h1);
    repeat (9) adjust(4'h8);
    repeat (9) adjust(4'ha);
    for (k = 0; k < 150; k++) begin
      seed = lfsr(seed);
      adjust(seed[3:0]);
    end
    i_ctl.mode_load(2'h1, reg1(3'h7, 2'h0, 1'b0));
    i_ctl.mode_load(2'h1, reg1(3'h0, 2'h0, 1'b0));
    check({pull_up_out, pull_down_out}, 8'h88);
    i_ctl.send_code(4'h1);
    check(pull_up_out, 4'h8);
    for (k = 0; k < 4; k++) begin
      i_ctl.mode_load(2'h1, reg1(3'h0, k[1:0], 1'b0));
      i_ctl.set_odt(1'b1);
      repeat (4) @(posedge mclk_in);
      #2 check({term_on_out, term_switch_out}, (k == 0) ? 4'h0 : {1'b1, 3'h1 << (k - 1)});
      i_ctl.set_odt(1'b0);
      repeat (4) @(posedge mclk_in);
      #2 check(term_on_out, 1'b0);
    end
    i_ctl.set_odt(1'b1);
    i_ctl.pulse_sr(1'b1);
    i_ctl.mode_load(2'h2, ~v);
    repeat (4) @(posedge mclk_in);
    #2 check({self_refresh_out, dll_on_out, term_on_out, emr2_out}, {3'h4, v});
    i_ctl.pulse_sr(1'b0);
    check({self_refresh_out, dll_on_out}, 2'h1);
    finish_test();
  end
endmodule : tb
